// ===== lmbc_pkg.sv
// constants for the link mode and serial bus control register pair
// assumes a 100 MHz device clock; all users reference names through lmbc_pkg::
package lmbc_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // register offsets and reset values
  localparam logic [7:0] OFFS_LINK_CONFIG_ONE = 8'h04;
  localparam logic [7:0] OFFS_SERIAL_CONTROL_OPTIONS = 8'h05;
  localparam logic [7:0] RST_LINK_CONFIG_ONE = 8'h80;
  localparam logic [7:0] RST_SERIAL_CONTROL_OPTIONS = 8'h00;
  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_LINK_CONFIG_ONE = 8'hBF;
  localparam logic [7:0] MASK_SERIAL_CONTROL_OPTIONS = 8'h1F;
  ////////////////////////////////////////////////////////////////////////////////
  // link_config_one fields
  localparam int BIT_FAILSAFE_LOW = 7;
  localparam int BIT_CRC_CLEAR = 5;
  localparam int BIT_DE_GATE = 4;
  localparam int BIT_COMPAT_BY_REG = 3;
  localparam int BIT_COMPAT_VALUE = 2;
  localparam int BIT_LOW_FREQ_BY_REG = 1;
  localparam int BIT_LOW_FREQ_VALUE = 0;
  // serial_control_options fields
  localparam int POS_SDA_DELAY_HI = 4;
  localparam int POS_SDA_DELAY_LO = 3;
  localparam int BIT_REMOTE_WR_BLOCK = 2;
  localparam int BIT_WD_SPEEDUP = 1;
  localparam int BIT_WD_DISABLE = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_MHZ = 100;
  localparam int SDA_DELAY_BASE_NS = 240;
  localparam int SDA_DELAY_STEP_NS = 40;
  localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
  localparam int WD_LONG_MS = 1000;
  localparam int WD_SHORT_MS = 50;
  localparam int WD_LONG_CYCLES = WD_LONG_MS * 1000 * CLOCK_MHZ;
  localparam int WD_SHORT_CYCLES = WD_SHORT_MS * 1000 * CLOCK_MHZ;
  localparam int RECOVERY_HALF_NS = 5000;
  localparam int RECOVERY_HALF_CYCLES = RECOVERY_HALF_NS / CLOCK_PERIOD_NS;
  localparam int RECOVERY_PULSES = 9;
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    WD_WATCH = 2'b00,
    WD_DRIVE_LOW = 2'b01,
    WD_RELEASE = 2'b10
  } lmbc_wd_state_type;
endpackage : lmbc_pkg

// ===== lmbc_regs.sv
// link mode and serial bus control registers with bus watchdog and data gating
// assumes the serial control slave presents decoded byte accesses on the
// reg_ port, and that all inputs are synchronous to clock
//
// Functional notes
// RULE1 - bit 7 of config register picks failsafe level, 1 low; reset value 0x80
// RULE2 - crc clear bit holds error counters at zero until software writes 0
// RULE3 - de gate bit masks colour data with data valid in legacy or unprotected use
// RULE4 - bit 3 chooses legacy mode source: 1 register bit 2, 0 strap pin
// RULE5 - under register control bit 2 set enables legacy compatibility
// RULE6 - bit 1 chooses frequency range source: 1 register bit 0, 0 strap pin
// RULE7 - under register control bit 0 set selects low 5 to 15 MHz range
// RULE8 - bus control bits 4:3 add 40 ns steps to the 240 ns SDA delay
// RULE9 - bus control bit 2 rejects register writes arriving from the remote side
// RULE10 - bus control bit 1 shortens the watchdog from about 1 s to 50 ms
// RULE11 - bus control bit 0 disables the bus watchdog
// RULE12 - SDA high and idle for the watchdog period means the bus is free
// RULE13 - SDA low and idle until expiry triggers nine recovery SCL pulses
// RULE14 - crc error flag clears on link loss or the crc clear bit
// RULE15 - reserved bits read zero and ignore writes; bus control resets to zero
module lmbc_regs #(
  parameter int WD_LONG_CYCLES = lmbc_pkg::WD_LONG_CYCLES,
  parameter int WD_SHORT_CYCLES = lmbc_pkg::WD_SHORT_CYCLES,
  parameter int RECOVERY_HALF_CYCLES = lmbc_pkg::RECOVERY_HALF_CYCLES,
  parameter int PIXEL_WIDTH = 24,
  parameter int COUNT_WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register access
  input wire logic reg_wr,
  input wire logic reg_wr_remote,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic write_rejected,
  // straps and mode outputs
  input wire logic strap_legacy_compat,
  input wire logic strap_low_freq,
  output logic failsafe_low,
  output logic legacy_compat,
  output logic low_freq_range_select,
  // colour path
  input wire logic [PIXEL_WIDTH-1:0] rgb_in,
  input wire logic data_valid_in,
  input wire logic partner_unprotected,
  output logic [PIXEL_WIDTH-1:0] rgb_out,
  // back channel crc
  input wire logic crc_error_event,
  input wire logic link_lost,
  output logic [COUNT_WIDTH-1:0] crc_error_count,
  output logic crc_error_flag,
  // serial bus pins and watchdog
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic [5:0] sda_delay_cycles,
  output logic bus_free
);
  ////////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] link_config_one;
  logic [7:0] serial_control_options;

  wire wr_blocked = reg_wr_remote & serial_control_options[lmbc_pkg::BIT_REMOTE_WR_BLOCK]; // RULE9
  wire wr_ok = reg_wr & ~wr_blocked;
  wire wr_cfg = wr_ok & (reg_addr == lmbc_pkg::OFFS_LINK_CONFIG_ONE);
  wire wr_ctl = wr_ok & (reg_addr == lmbc_pkg::OFFS_SERIAL_CONTROL_OPTIONS);
  wire [7:0] rd_mux = (reg_addr == lmbc_pkg::OFFS_LINK_CONFIG_ONE) ? link_config_one :
                      (reg_addr == lmbc_pkg::OFFS_SERIAL_CONTROL_OPTIONS) ?
                      serial_control_options : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_config_one <= lmbc_pkg::RST_LINK_CONFIG_ONE; // RULE1
      serial_control_options <= lmbc_pkg::RST_SERIAL_CONTROL_OPTIONS; // RULE15
      reg_rdata <= 8'h00;
      write_rejected <= 1'b0;
    end else if (clk_en) begin
      if (wr_cfg) begin
        link_config_one <= reg_wdata & lmbc_pkg::MASK_LINK_CONFIG_ONE; // RULE15
      end
      if (wr_ctl) begin
        serial_control_options <= reg_wdata & lmbc_pkg::MASK_SERIAL_CONTROL_OPTIONS; // RULE15
      end
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
      write_rejected <= reg_wr & wr_blocked; // RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode selection and colour gating
  wire crc_clear = link_config_one[lmbc_pkg::BIT_CRC_CLEAR];
  wire next_legacy = link_config_one[lmbc_pkg::BIT_COMPAT_BY_REG] ?
                     link_config_one[lmbc_pkg::BIT_COMPAT_VALUE] : strap_legacy_compat; // RULE4 RULE5
  wire next_low_freq = link_config_one[lmbc_pkg::BIT_LOW_FREQ_BY_REG] ?
                       link_config_one[lmbc_pkg::BIT_LOW_FREQ_VALUE] : strap_low_freq; // RULE6 RULE7
  // gating uses the registered mode, so it lags a mode change by one cycle
  wire gate_on = link_config_one[lmbc_pkg::BIT_DE_GATE] & (legacy_compat | partner_unprotected);
  wire [PIXEL_WIDTH-1:0] next_rgb = (gate_on & ~data_valid_in) ? '0 : rgb_in; // RULE3
  wire [1:0] delay_code = serial_control_options[lmbc_pkg::POS_SDA_DELAY_HI:lmbc_pkg::POS_SDA_DELAY_LO];
  wire [5:0] next_delay = 6'((lmbc_pkg::SDA_DELAY_BASE_NS + lmbc_pkg::SDA_DELAY_STEP_NS * int'(delay_code))
                             / lmbc_pkg::CLOCK_PERIOD_NS); // RULE8

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      failsafe_low <= lmbc_pkg::RST_LINK_CONFIG_ONE[lmbc_pkg::BIT_FAILSAFE_LOW];
      legacy_compat <= 1'b0;
      low_freq_range_select <= 1'b0;
      rgb_out <= '0;
      sda_delay_cycles <= 6'h00;
    end else if (clk_en) begin
      failsafe_low <= link_config_one[lmbc_pkg::BIT_FAILSAFE_LOW]; // RULE1
      legacy_compat <= next_legacy; // RULE4
      low_freq_range_select <= next_low_freq; // RULE6
      rgb_out <= next_rgb; // RULE3
      sda_delay_cycles <= next_delay; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crc error counter and flag; clear wins over a same-cycle error
  wire crc_hold = crc_clear | link_lost;
  wire count_full = &crc_error_count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crc_error_count <= '0;
      crc_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (crc_hold) begin
        crc_error_count <= '0; // RULE2
        crc_error_flag <= 1'b0; // RULE14
      end else if (crc_error_event) begin
        // saturate rather than wrap so software never sees a small false count
        crc_error_count <= count_full ? crc_error_count : crc_error_count + 1'b1;
        crc_error_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus watchdog and recovery
  lmbc_pkg::lmbc_wd_state_type wd_state;
  logic [31:0] idle_count;
  logic [31:0] half_count;
  logic [3:0] pulse_count;
  logic scl_prev;
  logic sda_prev;
  logic expired;

  wire wd_off = serial_control_options[lmbc_pkg::BIT_WD_DISABLE]; // RULE11
  wire [31:0] wd_limit = serial_control_options[lmbc_pkg::BIT_WD_SPEEDUP] ?
                         32'(WD_SHORT_CYCLES - 1) : 32'(WD_LONG_CYCLES - 1); // RULE10
  wire activity = (scl_in != scl_prev) | (sda_in != sda_prev);
  wire watching = (wd_state == lmbc_pkg::WD_WATCH);
  wire reach = watching & ~wd_off & ~activity & ~expired & (idle_count >= wd_limit);
  wire half_done = (half_count == 32'(RECOVERY_HALF_CYCLES - 1));
  wire last_pulse = (pulse_count == 4'(lmbc_pkg::RECOVERY_PULSES - 1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      idle_count <= 32'h0000_0000;
      expired <= 1'b0;
      bus_free <= 1'b0;
    end else if (clk_en) begin
      scl_prev <= scl_in;
      sda_prev <= sda_in;
      bus_free <= reach & sda_in; // RULE12
      if (wd_off | activity | ~watching) begin
        idle_count <= 32'h0000_0000;
        expired <= 1'b0;
      end else if (reach) begin
        expired <= 1'b1;
      end else if (~expired) begin
        idle_count <= idle_count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wd_state <= lmbc_pkg::WD_WATCH;
      half_count <= 32'h0000_0000;
      pulse_count <= 4'h0;
      scl_out <= 1'b1;
      scl_oe_n <= 1'b1;
    end else if (clk_en) begin
      unique case (wd_state)
        lmbc_pkg::WD_WATCH: begin
          half_count <= 32'h0000_0000;
          pulse_count <= 4'h0;
          if (reach & ~sda_in) begin
            wd_state <= lmbc_pkg::WD_DRIVE_LOW; // RULE13
            scl_out <= 1'b0;
            scl_oe_n <= 1'b0;
          end
        end
        lmbc_pkg::WD_DRIVE_LOW: begin
          half_count <= half_done ? 32'h0000_0000 : half_count + 32'h0000_0001;
          if (half_done) begin
            wd_state <= lmbc_pkg::WD_RELEASE;
            scl_out <= 1'b1;
            scl_oe_n <= 1'b1;
          end
        end
        lmbc_pkg::WD_RELEASE: begin
          half_count <= half_done ? 32'h0000_0000 : half_count + 32'h0000_0001;
          if (half_done) begin
            pulse_count <= pulse_count + 4'h1;
            if (last_pulse) begin
              wd_state <= lmbc_pkg::WD_WATCH; // RULE13
            end else begin
              wd_state <= lmbc_pkg::WD_DRIVE_LOW;
              scl_out <= 1'b0;
              scl_oe_n <= 1'b0;
            end
          end
        end
        default: begin
          wd_state <= lmbc_pkg::WD_WATCH;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // counts low phases of one recovery; a tenth would mean the pulse counter slipped
  logic [4:0] low_edges;
  wire next_drive_low = ((wd_state == lmbc_pkg::WD_WATCH) & reach & ~sda_in) |
                        ((wd_state == lmbc_pkg::WD_RELEASE) & half_done & ~last_pulse);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_edges <= 5'h00;
    end else if (clk_en) begin
      if (watching & ~(reach & ~sda_in)) begin
        low_edges <= 5'h00;
      end else if (next_drive_low) begin
        low_edges <= low_edges + 5'h01;
      end
    end
  end

  a_failsafe_follows: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> failsafe_low == $past(link_config_one[7])) else $error("failsafe level wrong"); // RULE1
  a_crc_held_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && crc_clear) |=> crc_error_count == '0 && !crc_error_flag)
    else $error("crc counter not held clear"); // RULE2
  a_rgb_gated: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && gate_on && !data_valid_in) |=> rgb_out == '0) else $error("colour not gated"); // RULE3
  a_legacy_source: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> legacy_compat == ($past(link_config_one[3]) ? $past(link_config_one[2]) :
                                 $past(strap_legacy_compat))) else $error("legacy source wrong"); // RULE4
  a_low_freq_source: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> low_freq_range_select == ($past(link_config_one[1]) ? $past(link_config_one[0]) :
                                         $past(strap_low_freq))) else $error("range source wrong"); // RULE6
  a_sda_delay_step: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> sda_delay_cycles == 6'(24 + 4 * $past(delay_code))) else $error("sda delay wrong"); // RULE8
  a_remote_blocked: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && reg_wr && wr_blocked) |=> $stable(link_config_one) && $stable(serial_control_options)
    && write_rejected) else $error("remote write not rejected"); // RULE9
  a_wd_disabled: assert property (@(posedge clock) disable iff (sys_rst)
    (wd_off && watching) |-> !reach && idle_count == 32'h0000_0000 || !$past(wd_off))
    else $error("watchdog active while disabled"); // RULE11
  a_free_on_high: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && reach && sda_in) |=> bus_free && wd_state == lmbc_pkg::WD_WATCH)
    else $error("free bus not reported"); // RULE12
  a_nine_pulses: assert property (@(posedge clock) disable iff (sys_rst)
    low_edges <= 5'd9) else $error("too many recovery pulses"); // RULE13
  a_nine_complete: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
    (clk_en && wd_state == lmbc_pkg::WD_RELEASE && half_done && last_pulse) |-> low_edges == 5'd9)
    else $error("recovery ended with wrong pulse count");
  a_scl_drive_pair: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
    scl_oe_n == scl_out) else $error("scl driven high");
  a_drive_on_low: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
    (clk_en && reach && !sda_in) |=> !scl_oe_n && !scl_out) else $error("hung bus not driven");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst) // RULE15
    (clk_en && reg_rd && reg_addr != lmbc_pkg::OFFS_LINK_CONFIG_ONE &&
    reg_addr != lmbc_pkg::OFFS_SERIAL_CONTROL_OPTIONS) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_crc_count_step: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
    (clk_en && crc_error_event && !crc_hold && !count_full) |=>
    crc_error_count == $past(crc_error_count) + 1'b1) else $error("crc count did not step");
  a_flag_on_error: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
    (clk_en && crc_error_event && !crc_hold) |=> crc_error_flag) else $error("crc flag not set");
  a_rgb_pass_valid: assert property (@(posedge clock) disable iff (sys_rst) // RULE3
    (clk_en && data_valid_in) |=> rgb_out == $past(rgb_in)) else $error("colour not passed");
  a_flag_link_loss: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && link_lost) |=> !crc_error_flag) else $error("flag kept over link loss"); // RULE14
  a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
    link_config_one[6] == 1'b0 && serial_control_options[7:5] == 3'h0)
    else $error("reserved bit set"); // RULE15
endmodule : lmbc_regs

// ===== lmbc_bus_master.sv
// far-side model: bus master that idles, pokes scl or hangs sda low
// assumes pull-ups on both lines and a 100 MHz bench clock
module lmbc_bus_master (
  // clock
  input wire logic clock,
  // bench controls
  input wire logic hang_low,
  input wire logic poke,
  // device side
  input wire logic scl_out,
  input wire logic scl_oe_n,
  output logic scl_in,
  output logic sda_in,
  output int pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic oe_q = 1'b1;
  int count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // released lines read high through the pull-ups, never a stale value
  assign scl_in = (scl_oe_n | scl_out) & ~poke;
  assign sda_in = ~hang_low;
  assign pulses = count;
  // count released edges of the device's scl drive, one per recovery pulse
  always @(posedge clock) begin
    oe_q <= scl_oe_n;
    if (scl_oe_n && !oe_q) begin
      count <= count + 1;
    end
  end
endmodule : lmbc_bus_master

// ===== test_link_mode_and_bus_control_regs.sv
// bench for the link mode and bus control registers
// assumes lmbc_regs with shortened watchdog counts and lmbc_bus_master
module test_link_mode_and_bus_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WD_LONG = 200;
  localparam int WD_SHORT = 50;
  logic clock = 0, sys_rst = 1, reg_wr = 0, reg_wr_remote = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic write_rejected, failsafe_low, legacy_compat, low_freq_range_select, rej;
  logic strap_legacy_compat = 0, strap_low_freq = 0, data_valid_in = 0;
  logic partner_unprotected = 0, crc_error_event = 0, link_lost = 0, hang_low = 0, poke = 0;
  logic [23:0] rgb_in = 0, rgb_out;
  logic [15:0] crc_error_count;
  logic crc_error_flag, scl_in, sda_in, scl_out, scl_oe_n, bus_free, e;
  logic [5:0] sda_delay_cycles;
  logic [7:0] gcfg [4] = '{8'h1C, 8'h10, 8'h0C, 8'h10};
  logic [3:0] pu = 4'b0110;
  int err_total = 0, n_tests = 0, cycles = 0, n, p0;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  lmbc_regs #(.WD_LONG_CYCLES(WD_LONG), .WD_SHORT_CYCLES(WD_SHORT),
    .RECOVERY_HALF_CYCLES(4)) dut_u (.clock, .sys_rst, .clk_en(1'b1), .reg_wr,
    .reg_wr_remote, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .write_rejected,
    .strap_legacy_compat, .strap_low_freq, .failsafe_low, .legacy_compat,
    .low_freq_range_select, .rgb_in, .data_valid_in, .partner_unprotected, .rgb_out,
    .crc_error_event, .link_lost, .crc_error_count, .crc_error_flag, .scl_in, .sda_in,
    .scl_out, .scl_oe_n, .sda_delay_cycles, .bus_free);
  lmbc_bus_master far_u (.clock, .hang_low, .poke, .scl_out, .scl_oe_n, .scl_in,
    .sda_in, .pulses(p0));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [23:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // strobes drop for a full cycle so back-to-back calls never double-assign
  task automatic wr(input logic [7:0] a, d, input logic rem);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_remote = rem;
    reg_wr = 1'b1;
    @(negedge clock);
    rej = write_rejected;
    reg_wr = 1'b0;
    reg_wr_remote = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("rdata", e, reg_rdata);
    @(negedge clock);
  endtask : rdc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask : pulse
  // cycles from a scl poke until bus_free, capped at 300
  task automatic wdw(input logic [7:0] cfg);
    wr(8'h05, cfg, 0);
    pulse(poke);
    n = 0;
    while (bus_free !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
  endtask : wdw
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    rdc(8'h04, 8'h80);
    rdc(8'h05, 8'h00);
    chk("failsafe", 1'b1, failsafe_low);
    wr(8'h10, 8'hFF, 0);
    rdc(8'h10, 8'h00);
    wr(8'h04, 8'hFF, 0);
    rdc(8'h04, 8'hBF);
    wr(8'h05, 8'hFF, 0);
    rdc(8'h05, 8'h1F);
    wr(8'h04, 8'h7F, 0);
    @(negedge clock);
    chk("failsafe", 1'b0, failsafe_low);
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, 8'(k << 3), 0);
      @(negedge clock);
      chk("sda_delay", 24'(24 + 4 * k), sda_delay_cycles);
    end
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      strap_legacy_compat = i[0];
      strap_low_freq = i[0];
      wr(8'h04, {4'h0, i[2], i[1], i[2], i[1]}, 0);
      @(negedge clock);
      e = i[2] ? i[1] : i[0];
      chk("legacy", e, legacy_compat);
      chk("low_freq", e, low_freq_range_select);
    end
    $display("test modes done");
    rgb_in = 24'hABCDEF;
    strap_legacy_compat = 1'b0;
    for (int j = 0; j < 4; j++) begin
      data_valid_in = 1'b0;
      partner_unprotected = pu[j];
      wr(8'h04, gcfg[j], 0);
      repeat (2) @(negedge clock);
      chk("rgb_gated", (j < 2) ? 24'h0 : 24'hABCDEF, rgb_out);
      data_valid_in = 1'b1;
      repeat (2) @(negedge clock);
      chk("rgb_valid", 24'hABCDEF, rgb_out);
    end
    $display("test gate done");
    wr(8'h04, 8'h00, 0);
    repeat (3) pulse(crc_error_event);
    chk("crc_count", 24'h3, crc_error_count);
    chk("crc_flag", 1'b1, crc_error_flag);
    wr(8'h04, 8'h20, 0);
    pulse(crc_error_event);
    chk("crc_count", 24'h0, crc_error_count);
    chk("crc_flag", 1'b0, crc_error_flag);
    wr(8'h04, 8'h00, 0);
    pulse(crc_error_event);
    chk("crc_count", 24'h1, crc_error_count);
    link_lost = 1'b1;
    repeat (2) @(negedge clock);
    link_lost = 1'b0;
    chk("crc_flag", 1'b0, crc_error_flag);
    $display("test crc done");
    wr(8'h05, 8'h04, 0);
    wr(8'h04, 8'h01, 1);
    chk("rejected", 1'b1, rej);
    rdc(8'h04, 8'h00);
    wr(8'h05, 8'h00, 0);
    wr(8'h04, 8'h01, 1);
    chk("rejected", 1'b0, rej);
    rdc(8'h04, 8'h01);
    $display("test remote done");
    wdw(8'h00);
    chk("wd_long", 1'b1, n >= WD_LONG - 2 && n <= WD_LONG + 4);
    wdw(8'h02);
    chk("wd_short", 1'b1, n >= WD_SHORT - 2 && n <= WD_SHORT + 4);
    wdw(8'h01);
    chk("wd_off", 1'b1, n == 300);
    n = p0;
    wr(8'h05, 8'h02, 0);
    hang_low = 1'b1;
    repeat (52) @(negedge clock);
    chk("scl_out", 1'b0, scl_out);
    chk("scl_oe_n", 1'b0, scl_oe_n);
    repeat (108) @(negedge clock);
    chk("recovery", 24'd9, 24'(p0 - n));
    hang_low = 1'b0;
    $display("test watchdog done");
    test_done();
  end
endmodule : test_link_mode_and_bus_control_regs
